// ### hdl/dma_source_address_reload.sv
`timescale 1ns/10ps
`include "dma_reload_params.svh"
// Overview of operation
// - With reload on, source address restored to start after every four units.
// - Byte units with increment advance source and destination by one.
// - Burst mode keeps bus granted between consecutive units.
// - With reload on, halt after fourth unit and drop bus request.
// - With reload off, continue past fourth unit, keep bus in burst mode, keep advancing.
// - Destination follows its own mode regardless of reload.
// - End interrupt only at count zero with enable set.
// - Clear requester flag at each reload halt and at transfer end, not after other units when reload off.
// - Count decrements by one after every unit.
// - Reload counter cleared by disables, end, nonmaskable, address error, reset, standby.
// - Reload works the same for 8, 16 and 32 bit units.
module dma_source_address_reload
    import dma_reload_pkg::*;
(
    // Clock and reset
    input  wire logic         clock_i,
    input  wire logic         sys_rst_i,
    // Configuration
    input  wire channel_cfg_t cfg_i,
    input  wire logic         standby_i,
    input  wire logic         nonmaskable_event_flag_i,
    input  wire logic         address_error_flag_i,
    // Register writes
    input  wire logic         src_wr_i,
    input  wire logic         dst_wr_i,
    input  wire logic         cnt_wr_i,
    input  wire logic [31:0]  wdata_i,
    // Requester
    input  wire logic         req_i,
    output logic              req_flag_clear_o,
    // Bus
    output logic              bus_req_o,
    input  wire logic         bus_grant_i,
    input  wire logic         unit_done_i,
    output bus_cycle_t        cycle_o,
    // Status
    output logic [31:0]       source_address_reg_o,
    output logic [31:0]       destination_address_reg_o,
    output logic [31:0]       transfer_count_reg_o,
    output logic              transfer_end_flag_o,
    output logic              end_irq_o
);
    logic [31:0] src_q, dst_q, cnt_q, src_start_q;
    logic [2:0]  units_q;
    logic        active_q, te_q, clr_q;
    logic        run_en, unit_ok, last_unit, reload_hit, counter_clr, te_set;

    function automatic logic [31:0] step_addr(input logic [31:0] a, input addr_mode_t m, input xfer_size_t s);
        logic [31:0] st;
        st = (s == SZ_LONG) ? `SIZE_LONG_STEP : (s == SZ_WORD) ? `SIZE_WORD_STEP : `SIZE_BYTE_STEP;
        unique case (m)
            AM_INC:  step_addr = a + st;
            AM_DEC:  step_addr = a - st;
            default: step_addr = a;
        endcase
    endfunction

    assign run_en     = cfg_i.master_transfer_enable & cfg_i.channel_transfer_enable & ~te_q
                        & ~nonmaskable_event_flag_i & ~address_error_flag_i & ~standby_i;
    assign unit_ok    = active_q & bus_grant_i & unit_done_i;
    assign last_unit  = cnt_q == 32'h0000_0001;
    assign reload_hit = unit_ok & cfg_i.reload_enable & (units_q == `RELOAD_UNITS - 3'd1);
    assign te_set     = unit_ok & last_unit;
    assign counter_clr = ~cfg_i.master_transfer_enable | ~cfg_i.channel_transfer_enable | te_set | te_q
                         | nonmaskable_event_flag_i | address_error_flag_i | standby_i;

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            src_start_q <= `ADDR_RST;
        else if (src_wr_i)
            src_start_q <= wdata_i;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            src_q <= `ADDR_RST;
        else if (src_wr_i)
            src_q <= wdata_i;
        else if (reload_hit)
            src_q <= src_start_q;
        else if (unit_ok)
            src_q <= step_addr(src_q, cfg_i.src_mode, cfg_i.size);
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            dst_q <= `ADDR_RST;
        else if (dst_wr_i)
            dst_q <= wdata_i;
        else if (unit_ok)
            dst_q <= step_addr(dst_q, cfg_i.dst_mode, cfg_i.size);
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            cnt_q <= `COUNT_RST;
        else if (cnt_wr_i)
            cnt_q <= wdata_i;
        else if (unit_ok)
            cnt_q <= cnt_q - 32'h0000_0001;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i || counter_clr || reload_hit)
            units_q <= 3'd0;
        else if (unit_ok)
            units_q <= units_q + 3'd1;
    end

    // end flag, cleared while the channel transfer enable is off
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            te_q <= 1'b0;
        else if (te_set)
            te_q <= 1'b1;
        else if (~cfg_i.channel_transfer_enable)
            te_q <= 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            active_q <= 1'b0;
        else if (~run_en || te_set || reload_hit)
            active_q <= 1'b0;
        else if (unit_ok && !cfg_i.burst_mode)
            active_q <= 1'b0;
        else if (req_i && cnt_q != 32'h0000_0000)
            active_q <= 1'b1;
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
            clr_q <= 1'b0;
        else
            clr_q <= reload_hit | te_set;
    end

    assign bus_req_o                 = active_q;
    assign req_flag_clear_o          = clr_q;
    assign cycle_o                   = '{valid: active_q & bus_grant_i, src: src_q, dst: dst_q};
    assign source_address_reg_o      = src_q;
    assign destination_address_reg_o = dst_q;
    assign transfer_count_reg_o      = cnt_q;
    assign transfer_end_flag_o       = te_q;
    assign end_irq_o                 = te_q & cfg_i.end_interrupt_enable;

    property p_reload_src;
        @(posedge clock_i) disable iff (sys_rst_i) reload_hit && !src_wr_i |=> src_q == $past(src_start_q);
    endproperty
    a_reload_src: assert property (p_reload_src) else $error("source not reloaded");
    property p_byte_inc;
        @(posedge clock_i) disable iff (sys_rst_i)
            unit_ok && !reload_hit && !src_wr_i && cfg_i.size == SZ_BYTE && cfg_i.src_mode == AM_INC
            |=> src_q == $past(src_q) + 32'h0000_0001;
    endproperty
    a_byte_inc: assert property (p_byte_inc) else $error("byte step wrong");
    property p_burst_keep;
        @(posedge clock_i) disable iff (sys_rst_i)
            unit_ok && cfg_i.burst_mode && !reload_hit && !te_set && run_en |=> bus_req_o;
    endproperty
    a_burst_keep: assert property (p_burst_keep) else $error("burst lost bus");
    property p_halt;
        @(posedge clock_i) disable iff (sys_rst_i) reload_hit |=> !bus_req_o;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt at reload");
    // Fourth unit with reload off keeps the bus and keeps counting
    property p_no_reload_off;
        @(posedge clock_i) disable iff (sys_rst_i)
            !cfg_i.reload_enable && cfg_i.burst_mode && unit_ok && units_q == 3'd3 && !te_set && run_en
            |=> bus_req_o && units_q == 3'd4;
    endproperty
    a_no_reload_off: assert property (p_no_reload_off) else $error("reload while off");
    property p_irq;
        @(posedge clock_i) disable iff (sys_rst_i) te_set && cfg_i.end_interrupt_enable |=> end_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("end interrupt missing");
    property p_irq_halt;
        @(posedge clock_i) disable iff (sys_rst_i) reload_hit && !te_set |=> !end_irq_o;
    endproperty
    a_irq_halt: assert property (p_irq_halt) else $error("interrupt at reload halt");
    property p_flag_clr;
        @(posedge clock_i) disable iff (sys_rst_i) reload_hit |=> req_flag_clear_o;
    endproperty
    a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
    property p_no_clr_off;
        @(posedge clock_i) disable iff (sys_rst_i)
            !cfg_i.reload_enable && unit_ok && !last_unit |=> !req_flag_clear_o;
    endproperty
    a_no_clr_off: assert property (p_no_clr_off) else $error("flag cleared with reload off");
    property p_count;
        @(posedge clock_i) disable iff (sys_rst_i) unit_ok && !cnt_wr_i |=> cnt_q == $past(cnt_q) - 32'h0000_0001;
    endproperty
    a_count: assert property (p_count) else $error("count not decremented");
    property p_ctr_clr;
        @(posedge clock_i) disable iff (sys_rst_i)
            counter_clr && !unit_ok && !src_wr_i && !dst_wr_i && !cnt_wr_i
            |=> units_q == 3'd0 && src_q == $past(src_q) && dst_q == $past(dst_q) && cnt_q == $past(cnt_q);
    endproperty
    a_ctr_clr: assert property (p_ctr_clr) else $error("unit counter not cleared");
    property p_end;
        @(posedge clock_i) disable iff (sys_rst_i) te_set |=> transfer_end_flag_o && !bus_req_o;
    endproperty
    a_end: assert property (p_end) else $error("end not flagged");
    c_reload: cover property (@(posedge clock_i) reload_hit);
    c_halt_src: cover property (@(posedge clock_i)
        active_q && (standby_i || nonmaskable_event_flag_i || address_error_flag_i));
    c_end: cover property (@(posedge clock_i) te_set && end_irq_o == 1'b0 ##1 end_irq_o);
    c_off_fifth: cover property (@(posedge clock_i) unit_ok && !cfg_i.reload_enable && units_q == 3'd4);
endmodule

// ### hdl/dma_reload_params.svh
`ifndef DMA_RELOAD_PARAMS_SVH
`define DMA_RELOAD_PARAMS_SVH
`define RELOAD_UNITS      3'd4
`define ADDR_RST          32'h0000_0000
`define COUNT_RST         32'h0000_0000
`define SIZE_BYTE_STEP    32'h0000_0001
`define SIZE_WORD_STEP    32'h0000_0002
`define SIZE_LONG_STEP    32'h0000_0004
`endif

// ### hdl/dma_reload_pkg.sv
package dma_reload_pkg;
    typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} xfer_size_t;
    typedef enum logic [1:0] {AM_FIXED, AM_INC, AM_DEC} addr_mode_t;
    typedef struct packed {
        logic       master_transfer_enable;
        logic       channel_transfer_enable;
        logic       end_interrupt_enable;
        logic       reload_enable;
        logic       burst_mode;
        xfer_size_t size;
        addr_mode_t src_mode;
        addr_mode_t dst_mode;
    } channel_cfg_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] src;
        logic [31:0] dst;
    } bus_cycle_t;
endpackage

// ### tb/dma_bus_partner.sv
`timescale 1ns/10ps
// Bus master and arbiter beside the channel: grants one cycle after a request
module dma_bus_partner
    import dma_reload_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    // Channel side
    input  wire logic       bus_req_i,
    input  wire bus_cycle_t cycle_i,
    input  wire logic       stall_i,
    output logic            bus_grant_o,
    output logic            unit_done_o
);
    always_ff @(posedge clock_i)
    begin
        bus_grant_o <= !sys_rst_i && bus_req_i;
    end
    // Stall stretches a unit over extra cycles
    assign unit_done_o = bus_grant_o && cycle_i.valid && !stall_i;
endmodule

// ### tb/dma_source_address_reload_tb.sv
`timescale 1ns/10ps
module dma_source_address_reload_tb
    import dma_reload_pkg::*;
;
    typedef struct packed {logic rl; xfer_size_t sz; logic slow; logic [31:0] step;} row_t;
    logic         clock_i, sys_rst_i, slow, src_wr, dst_wr, cnt_wr, req, stall, grant, done;
    logic [2:0]   halt_src;
    logic         req_clr, bus_req, te, irq;
    logic [31:0]  wdata, src, dst, cnt;
    channel_cfg_t cfg;
    bus_cycle_t   cyc;
    int           error_cnt, samples_checked;
    row_t         rows [0:3];
    const logic [31:0] A = 32'hffff83f0, B = 32'hfffff000;
    addr_mode_t   dmode [0:2] = '{AM_DEC, AM_FIXED, AM_INC};
    logic [31:0]  dstep [0:2] = '{32'hffff_ffff, 32'h0000_0000, 32'h0000_0001};
    dma_source_address_reload i_dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .cfg_i(cfg),
        .standby_i(halt_src[0]), .nonmaskable_event_flag_i(halt_src[1]),
        .address_error_flag_i(halt_src[2]), .src_wr_i(src_wr), .dst_wr_i(dst_wr),
        .cnt_wr_i(cnt_wr), .wdata_i(wdata), .req_i(req), .req_flag_clear_o(req_clr), .bus_req_o(bus_req),
        .bus_grant_i(grant), .unit_done_i(done), .cycle_o(cyc), .source_address_reg_o(src),
        .destination_address_reg_o(dst), .transfer_count_reg_o(cnt), .transfer_end_flag_o(te),
        .end_irq_o(irq));
    dma_bus_partner i_bus (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .bus_req_i(bus_req), .cycle_i(cyc),
        .stall_i(stall), .bus_grant_o(grant), .unit_done_o(done));
    initial
    begin
        clock_i = 0;
        forever #4 clock_i = ~clock_i;
    end
    task automatic end_sim();
        $display("checked %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input int sel, input logic [31:0] d);
        @(posedge clock_i);
        {src_wr, dst_wr, cnt_wr} <= 3'h4 >> sel;
        wdata <= d;
        @(posedge clock_i);
        {src_wr, dst_wr, cnt_wr} <= 3'h0;
    endtask
    task automatic pulse_req();
        @(posedge clock_i);
        req <= 1'b1;
        @(posedge clock_i);
        req <= 1'b0;
    endtask
    // Counts units taken, then stops just after the edge that takes the last one
    task automatic wait_units(input int n);
        int k, seen;
        seen = 0;
        for (k = 0; k < 200 && seen < n; k++)
        begin
            @(negedge clock_i);
            if (bus_req === 1'b1 && grant === 1'b1 && done === 1'b1)
                seen++;
        end
        if (seen < n)
        begin
            error_cnt++;
            $display("MISMATCH units expected %0d seen %0d", n, seen);
            end_sim();
        end
        @(posedge clock_i);
        #1;
    endtask
    always @(posedge clock_i)
        stall <= cfg.burst_mode && slow && !stall && bus_req;
    initial
    begin
        {halt_src, slow, src_wr, dst_wr, cnt_wr, req, wdata, error_cnt, samples_checked} = '0;
        cfg = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, SZ_BYTE, AM_INC, AM_INC};
        rows = '{'{1'b1, SZ_BYTE, 1'b0, 32'h1}, '{1'b0, SZ_BYTE, 1'b1, 32'h1},
                 '{1'b1, SZ_WORD, 1'b0, 32'h2}, '{1'b1, SZ_LONG, 1'b0, 32'h4}};
        sys_rst_i = 1;
        repeat (12) @(posedge clock_i);
        sys_rst_i <= 0;
        #1;
        chk("rst", {src, dst, cnt, 28'h0, bus_req, req_clr, te, irq}, '0);
        foreach (rows[i])
        begin
            cfg <= '{1'b1, 1'b0, 1'b1, rows[i].rl, 1'b1, rows[i].sz, AM_INC, AM_INC};
            slow <= rows[i].slow;
            wr(0, A);
            wr(1, B);
            wr(2, 32'h8);
            cfg.channel_transfer_enable <= 1'b1;
            pulse_req();
            wait_units(4);
            chk("src", src, rows[i].rl ? A : A + 4 * rows[i].step);
            chk("dst", dst, B + 4 * rows[i].step);
            chk("cnt", cnt, 32'h4);
            chk("bus", bus_req, !rows[i].rl);
            chk("irq", irq, 1'b0);
            chk("clr", req_clr, rows[i].rl);
            if (rows[i].rl)
                pulse_req();
            wait_units(4);
            chk("src_end", src, rows[i].rl ? A : A + 8 * rows[i].step);
            chk("dst_end", dst, B + 8 * rows[i].step);
            chk("end", {cnt, te, irq, bus_req}, {32'h0, 3'h6});
        end
        pulse_req();
        repeat (3) @(posedge clock_i);
        #1;
        chk("refused", {bus_req, cnt}, '0);
        cfg.end_interrupt_enable <= 1'b0;
        @(posedge clock_i);
        #1;
        chk("irq_off", {te, irq}, 2'h2);
        // each halt source lets the unit in hand finish, then stops the channel and clears the unit counter
        for (int k = 0; k < 3; k++)
        begin
            cfg <= '{1'b1, 1'b0, 1'b1, 1'b1, 1'b1, SZ_BYTE, AM_INC, dmode[k]};
            wr(0, A);
            wr(1, B);
            wr(2, 32'h8);
            cfg.channel_transfer_enable <= 1'b1;
            pulse_req();
            wait_units(1);
            @(posedge clock_i);
            halt_src <= 3'h1 << k;
            @(posedge clock_i);
            halt_src <= 3'h0;
            #1;
            chk("halt", {bus_req, src, cnt}, {1'b0, A + 32'h3, 32'h5});
            chk("halt_dst", dst, 32'(B + 3 * dstep[k]));
            pulse_req();
            wait_units(4);
            chk("resume", {bus_req, src, cnt, req_clr}, {1'b0, A, 32'h1, 1'b1});
            chk("resume_dst", dst, 32'(B + 7 * dstep[k]));
        end
        end_sim();
    end
endmodule
